// ==== logic/abac_defs.vh ====
// Purpose: Constants for the burst/accumulate converter sequencer
// Assumes: 25 MHz system clock, 32-bit classic Wishbone register word
// Notes: Offsets are byte addresses of aligned words
`ifndef ABAC_DEFS_VH
`define ABAC_DEFS_VH

// Register offsets
`define ABAC_CTRL_OFS 4'h0
`define ABAC_CFG_OFS 4'h4
`define ABAC_RES_OFS 4'h8
`define ABAC_WIN_OFS 4'hc

// Control register fields
`define ABAC_CTRL_EN 0
`define ABAC_CTRL_BURST 1
`define ABAC_CTRL_LJST 2
`define ABAC_CTRL_START 3
`define ABAC_CTRL_BUSY 4
`define ABAC_CTRL_DONE 5
`define ABAC_CTRL_WIN 6

// Config register reset value
`define ABAC_CFG_RST 8'h04

// Tracking mode encodings
`define ABAC_TM_PRE 2'b10
`define ABAC_TM_POST 2'b01
`define ABAC_TM_DUAL 2'b11

// Timing
`define ABAC_CLK_NS 40
`define ABAC_PWRUP_STEP_NS 1000
`define ABAC_PWRUP_STEP_CYC ((`ABAC_PWRUP_STEP_NS + `ABAC_CLK_NS - 1) / `ABAC_CLK_NS)
`define ABAC_SAR_DIV 2
`define ABAC_SAR_CYC 13
`define ABAC_EDGE_CYC 2
`define ABAC_CONV_CYC (`ABAC_SAR_CYC * `ABAC_SAR_DIV + `ABAC_EDGE_CYC)
`define ABAC_BURST_DIV 1

`endif

// ==== logic/abac_ctrl.v ====
// Purpose: Burst sequencing, accumulation and result formatting for a 12-bit converter
// Assumes: One clock; burst oscillator modelled as an enable from a divider
// Notes: Registers reached over classic Wishbone, one word per register
`timescale 1ns/1ns
`include "abac_defs.vh"

// Function
// - Burst: wake, run 1/4/8/16 samples, sleep
// - Burst clock independent of system clock; here it is an enable from a divider on clk_sys
// - Burst active only while enable bit set
// - converter_enable selects idle power state
// - Power up and wait delay if down; only burst with converter_enable clear waits, other starts convert at once with pre-tracking, else track first
// - Burst: one start runs whole series
// - Done flag only after full series
// - Window compare only on complete sum
// - Single sample: 12-bit result each conversion
// - left_justify_sel picks alignment 0x0FFF/0xFFF0
// - Unused result bits read zero
// - Series sum written after last conversion
// - repeat_count_sel picks 1, 4, 8, 16
// - Subsystem clock: system or burst source
// - Conversion: 13 SAR plus 2 cycles
// - Tracking: track time plus 2 cycles
// - Tracking encodings 10b, 01b, 11b
module abac_ctrl (
	input wire clk_sys,
	input wire rst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire ext_start,
	input wire [11:0] sample_data,
	output reg conv_power,
	output reg conv_track,
	output reg conv_active
);

	localparam ST_IDLE = 2'd0;
	localparam ST_PWRUP = 2'd1;
	localparam ST_TRACK = 2'd2;
	localparam ST_CONV = 2'd3;
	// Cycle counts held as 32-bit constants and cut to the 8-bit counter where used;
	// every count here fits, so the cut never loses a bit
	localparam [31:0] CONV_CYC_W = `ABAC_CONV_CYC;
	localparam [31:0] EDGE_CYC_W = `ABAC_EDGE_CYC;
	localparam [31:0] PWRUP_STEP_W = `ABAC_PWRUP_STEP_CYC;
	localparam [31:0] BURST_LAST_W = `ABAC_BURST_DIV - 1;

	reg converter_enable_reg;
	reg burst_mode_enable_reg;
	reg left_justify_sel_reg;
	reg conversion_done_flag_reg;
	reg window_flag_reg;
	reg [7:0] cfg_reg;
	reg [15:0] result_reg;
	reg [15:0] gt_thresh_reg;
	reg [15:0] lt_thresh_reg;
	reg [1:0] state_reg;
	reg [7:0] cnt_reg;
	reg [3:0] sample_cnt_reg;
	reg [15:0] acc_reg;
	reg [11:0] smp_meta_reg;
	reg [11:0] smp_sync_reg;
	reg [2:0] ext_sync_reg;
	reg [7:0] div_reg;
	reg burst_tick_reg;
	reg sw_start_reg;

	wire [1:0] repeat_count_sel = cfg_reg[1:0];
	wire [1:0] tracking_mode_sel = cfg_reg[3:2];
	wire [1:0] post_start_track_time = cfg_reg[5:4];
	wire [1:0] power_up_delay_sel = cfg_reg[7:6];
	// Bus decode; the registered ack masks a strobe still held after its answer
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
	wire ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];
	wire start_pulse = sw_start_reg | ext_rise;
	reg [3:0] last_idx;
	reg converter_subsystem_clock_en;
	reg [15:0] sum_next;
	reg [15:0] result_next;
	// Tracking reload: programmed time plus the two edge cycles
	wire [7:0] track_load = {6'h00, post_start_track_time} + EDGE_CYC_W[7:0];
	// Power-up wait in system cycles; the longest setting is four steps
	wire [7:0] pwrup_load = ({6'h00, power_up_delay_sel} + 8'h01) * PWRUP_STEP_W[7:0];

	// Repeat count decode and subsystem clock source
	always @* begin
		case (repeat_count_sel)
		2'b00: last_idx = 4'h0;
		2'b01: last_idx = 4'h3;
		2'b10: last_idx = 4'h7;
		default: last_idx = 4'hf;
		endcase
		converter_subsystem_clock_en = burst_mode_enable_reg ? burst_tick_reg : 1'b1;
		sum_next = acc_reg + {4'h0, smp_sync_reg};
		// Left alignment only means something for a single sample
		if (repeat_count_sel == 2'b00 && left_justify_sel_reg) begin
			result_next = {smp_sync_reg, 4'h0};
		end else begin
			result_next = sum_next;
		end
	end

	// Burst oscillator stand-in: runs whatever the register traffic does
	// With a divider of one the enable is high on every cycle after reset
	always @(posedge clk_sys) begin
		if (rst) begin
			div_reg <= 8'h00;
			burst_tick_reg <= 1'b0;
		end else if (div_reg == BURST_LAST_W[7:0]) begin
			div_reg <= 8'h00;
			burst_tick_reg <= 1'b1;
		end else begin
			div_reg <= div_reg + 8'h01;
			burst_tick_reg <= 1'b0;
		end
	end

	// Pin synchronisers; the first stage feeds only the second
	always @(posedge clk_sys) begin
		if (rst) begin
			smp_meta_reg <= 12'h000;
			smp_sync_reg <= 12'h000;
			ext_sync_reg <= 3'h0;
		end else begin
			smp_meta_reg <= sample_data;
			smp_sync_reg <= smp_meta_reg;
			ext_sync_reg <= {ext_sync_reg[1:0], ext_start};
		end
	end

	// Sequencer: power-up, track, convert, accumulate
	always @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 8'h00;
			sample_cnt_reg <= 4'h0;
			acc_reg <= 16'h0000;
			result_reg <= 16'h0000;
			conv_power <= 1'b0;
			conv_track <= 1'b0;
			conv_active <= 1'b0;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				// Idle power follows converter_enable in both modes
				conv_power <= converter_enable_reg;
				conv_track <= converter_enable_reg && tracking_mode_sel[1];
				conv_active <= 1'b0;
				// A start that arrives while busy is dropped: only idle listens
				if (start_pulse && (burst_mode_enable_reg || converter_enable_reg)) begin
					conv_active <= 1'b1;
					conv_power <= 1'b1;
					if (sample_cnt_reg == 4'h0) begin
						acc_reg <= 16'h0000;
					end
					if (burst_mode_enable_reg && !converter_enable_reg) begin
						state_reg <= ST_PWRUP;
						cnt_reg <= pwrup_load;
					end else if (tracking_mode_sel == `ABAC_TM_PRE) begin
						state_reg <= ST_CONV;
						conv_track <= 1'b0;
						cnt_reg <= CONV_CYC_W[7:0];
					end else begin
						state_reg <= ST_TRACK;
						conv_track <= 1'b1;
						cnt_reg <= track_load;
					end
				end
			end
			ST_PWRUP: begin
				// Power-up wait counts system cycles, not burst ticks
				if (cnt_reg <= 8'h01) begin
					state_reg <= ST_TRACK;
					conv_track <= 1'b1;
					cnt_reg <= track_load;
				end else begin
					cnt_reg <= cnt_reg - 8'h01;
				end
			end
			ST_TRACK: begin
				// Counts subsystem clocks, so burst timing follows the burst enable
				if (converter_subsystem_clock_en) begin
					if (cnt_reg <= 8'h01) begin
						state_reg <= ST_CONV;
						conv_track <= 1'b0;
						cnt_reg <= CONV_CYC_W[7:0];
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
			end
			ST_CONV: begin
				// The sample is taken on the last conversion cycle, after two sync stages
				if (converter_subsystem_clock_en && cnt_reg <= 8'h01) begin
					acc_reg <= sum_next;
					if (sample_cnt_reg == last_idx) begin
						// Whole series in: publish and return to idle power
						sample_cnt_reg <= 4'h0;
						result_reg <= result_next;
						state_reg <= ST_IDLE;
						conv_active <= 1'b0;
						conv_power <= converter_enable_reg;
						conv_track <= converter_enable_reg && tracking_mode_sel[1];
					end else if (burst_mode_enable_reg) begin
						sample_cnt_reg <= sample_cnt_reg + 4'h1;
						state_reg <= ST_TRACK;
						conv_track <= 1'b1;
						cnt_reg <= track_load;
					end else begin
						// Non-burst waits for the next start per sample
						sample_cnt_reg <= sample_cnt_reg + 4'h1;
						state_reg <= ST_IDLE;
						conv_active <= 1'b0;
					end
				end else if (converter_subsystem_clock_en) begin
					cnt_reg <= cnt_reg - 8'h01;
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Series completion strobe, same cycle the result register loads
	wire series_done = (state_reg == ST_CONV) && converter_subsystem_clock_en && (cnt_reg <= 8'h01)
		&& (sample_cnt_reg == last_idx);
	// Window test looks at the finished sum, never a partial one
	// Thresholds compare in the same alignment as the published result
	wire window_hit = (result_next > gt_thresh_reg) && (result_next < lt_thresh_reg);

	// Register writes; hardware set beats a software clear in the same cycle
	always @(posedge clk_sys) begin
		if (rst) begin
			converter_enable_reg <= 1'b0;
			burst_mode_enable_reg <= 1'b0;
			left_justify_sel_reg <= 1'b0;
			conversion_done_flag_reg <= 1'b0;
			window_flag_reg <= 1'b0;
			sw_start_reg <= 1'b0;
			cfg_reg <= `ABAC_CFG_RST;
			gt_thresh_reg <= 16'h0000;
			lt_thresh_reg <= 16'hffff;
		end else begin
			sw_start_reg <= bus_wr && (wb_adr_i == `ABAC_CTRL_OFS) && wb_dat_i[`ABAC_CTRL_START];
			if (bus_wr && wb_adr_i == `ABAC_CTRL_OFS) begin
				converter_enable_reg <= wb_dat_i[`ABAC_CTRL_EN];
				burst_mode_enable_reg <= wb_dat_i[`ABAC_CTRL_BURST];
				left_justify_sel_reg <= wb_dat_i[`ABAC_CTRL_LJST];
				if (wb_dat_i[`ABAC_CTRL_DONE]) begin
					conversion_done_flag_reg <= 1'b0;
				end
				if (wb_dat_i[`ABAC_CTRL_WIN]) begin
					window_flag_reg <= 1'b0;
				end
			end
			if (bus_wr && wb_adr_i == `ABAC_CFG_OFS) begin
				cfg_reg <= wb_dat_i[7:0];
			end
			if (bus_wr && wb_adr_i == `ABAC_WIN_OFS) begin
				gt_thresh_reg <= wb_dat_i[15:0];
				lt_thresh_reg <= wb_dat_i[31:16];
			end
			if (series_done) begin
				conversion_done_flag_reg <= 1'b1;
				if (window_hit) begin
					window_flag_reg <= 1'b1;
				end
			end
		end
	end

	// Wishbone answer: one wait state, unmapped reads return zero
	always @(posedge clk_sys) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h00000000;
			if (bus_req) begin
				case (wb_adr_i)
				`ABAC_CTRL_OFS: wb_dat_o <= {25'h0000000, window_flag_reg,
					conversion_done_flag_reg, conv_active, 1'b0, left_justify_sel_reg,
					burst_mode_enable_reg, converter_enable_reg};
				`ABAC_CFG_OFS: wb_dat_o <= {24'h000000, cfg_reg};
				`ABAC_RES_OFS: wb_dat_o <= {16'h0000, result_reg};
				`ABAC_WIN_OFS: wb_dat_o <= {lt_thresh_reg, gt_thresh_reg};
				default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

endmodule // abac_ctrl

// ==== dv/abac_ctrl_sva.sv ====
// Purpose: Port checks for the converter sequencer
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every abac_ctrl instance
`timescale 1ns/1ns
module abac_ctrl_sva (
	input wire clk_sys,
	input wire rst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire [3:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire conv_power,
	input wire conv_track,
	input wire conv_active
);
	// Single domain, so clock and reset are shared
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// Bus answers a fresh request next cycle, for one cycle only
	chk_ack_resp: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data without ack");
	// Result word never uses the upper half
	chk_res_upper: assert property (
		wb_ack_o && $past(wb_adr_i) == 4'h8 |-> wb_dat_o[31:16] == 16'h0)
		else $error("result upper bits set");
	// Tracking needs power; a short track or convert hints at a bad count
	chk_track_power: assert property (conv_track |-> conv_power)
		else $error("tracking while off");
	chk_track_len: assert property (
		$rose(conv_track) && conv_active |-> conv_track [*2])
		else $error("tracking too short");
	chk_conv_len: assert property (
		$fell(conv_track) && conv_active |-> conv_active [*8])
		else $error("conversion too short");
	chk_power_idle: assert property ($fell(conv_power) |-> !conv_active)
		else $error("power lost while busy");
endmodule // abac_ctrl_sva

bind abac_ctrl abac_ctrl_sva u_sva (.clk_sys(clk_sys), .rst(rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_power(conv_power),
	.conv_track(conv_track), .conv_active(conv_active));

// ==== dv/abac_ctrl_tb_top.sv ====
// Purpose: Register-level tests of the converter sequencer
// Assumes: 25 MHz clock; the bench drives every port itself
// Notes: Samples are held constant so sums are exact
`timescale 1ns/1ns
module abac_ctrl_tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0;
	logic ext_start = 1'b0;
	logic [11:0] sample_data = 12'h0;
	wire [31:0] wb_dat_o;
	wire wb_ack_o;
	wire conv_power;
	wire conv_track;
	wire conv_active;
	logic [31:0] rd;
	int fail_count = 0;
	int num_checks = 0;
	int cyc_cnt = 0;
	int k;
	int t0;
	int exp_cyc;
	logic [31:0] cfg_w;

	always #20 clk_sys = ~clk_sys;

	abac_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_start(ext_start),
		.sample_data(sample_data), .conv_power(conv_power),
		.conv_track(conv_track), .conv_active(conv_active));

	task final_report;
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One classic cycle, held until ack is seen at an edge
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask

	task rdc(input logic [3:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// Polls control; only the global timeout ends a hang
	task wbit(input int b, input logic v);
		do wb(1'b0, 4'h0, 32'h0); while (rd[b] !== v);
	endtask

	// Ceiling well above the fewer than two thousand cycles the tests need
	always @(posedge clk_sys) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			fail_count++;
			final_report;
		end
	end

	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		rdc(4'h0, 32'h0);
		rdc(4'h4, 32'h4);
		rdc(4'h2, 32'h0);
		wb(1'b1, 4'hc, 32'h2000_0000);
		// Single samples, pre-tracking, both alignments
		sample_data <= 12'hfff;
		wb(1'b1, 4'h4, 32'h8);
		wb(1'b1, 4'h0, 32'h9);
		wbit(5, 1'b1);
		rdc(4'h8, 32'h0fff);
		wb(1'b1, 4'h0, 32'h6d);
		wbit(5, 1'b1);
		rdc(4'h8, 32'hfff0);
		// No burst, count 4: each start gives one conversion; partial sum is inside window
		sample_data <= 12'h7ff;
		wb(1'b1, 4'h4, 32'h5);
		wb(1'b1, 4'h0, 32'h69);
		wbit(4, 1'b0);
		rdc(4'h0, 32'h1);
		repeat (3) begin
			wb(1'b1, 4'h0, 32'h9);
			wbit(4, 1'b0);
		end
		rdc(4'h0, 32'h61);
		rdc(4'h8, 32'h1ffc);
		// Burst, powered down between series, counts 4, 8, 16
		sample_data <= 12'hfff;
		for (k = 1; k < 4; k++) begin
			// Last pass uses the longest power-up and tracking settings
			cfg_w = {24'h0, (k == 3) ? 4'hf : 4'h0, (k == 2) ? 2'b11 : 2'b01, k[1:0]};
			wb(1'b1, 4'h4, cfg_w);
			wb(1'b1, 4'h0, 32'h6a);
			t0 = cyc_cnt;
			// Power-up steps of 25 cycles, then per sample track time plus 2 and 28
			exp_cyc = (k == 3) ? 100 + 16 * 33 : 25 + (2 << k) * 30;
			wbit(5, 1'b1);
			t0 = cyc_cnt - t0;
			// Polling adds two to four cycles after the done edge
			chk(t0 >= exp_cyc && t0 <= exp_cyc + 6, 1'b1);
			rdc(4'h8, 32'hfff << (k + 1));
			rdc(4'h0, 32'h22);
			chk(conv_power, 1'b0);
		end
		// Burst kept powered, started from the pin
		wb(1'b1, 4'h4, 32'h5);
		wb(1'b1, 4'h0, 32'h63);
		ext_start <= 1'b1;
		repeat (4) @(posedge clk_sys);
		ext_start <= 1'b0;
		wbit(5, 1'b1);
		rdc(4'h8, 32'h3ffc);
		chk(conv_power, 1'b1);
		// Burst off and converter off: start is ignored
		wb(1'b1, 4'h0, 32'h68);
		rdc(4'h0, 32'h0);
		// Reset while idle returns config, window and result registers to their reset values
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rdc(4'h4, 32'h4);
		rdc(4'hc, 32'hffff0000);
		rdc(4'h8, 32'h0);
		final_report;
	end
endmodule // abac_ctrl_tb_top
